// *** egcp_pad_model.sv ***
// Pin-side model: external switches, pulls and the fixed pull-up on the last pin
`timescale 1ns/100ps
`default_nettype none
module egcp_pad_model (
  input wire logic core_clk,
  input wire logic [4:0] pad_o,
  input wire logic [4:0] pad_oe,
  input wire logic [4:0] pull_up,
  input wire logic [4:0] pull_down,
  input wire logic [4:0] sw_closed,
  output logic [4:0] pad_i
);
  logic flt_q = 1'b0;
  // A floating pin shows a changing pattern
  always_ff @(posedge core_clk) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (sw_closed[i]) pad_i[i] = 1'b0;
      else if (pad_oe[i]) pad_i[i] = pad_o[i];
      else if (pull_up[i] || i == 4) pad_i[i] = 1'b1;
      else if (pull_down[i]) pad_i[i] = 1'b0;
      else pad_i[i] = flt_q;
    end
  end
endmodule : egcp_pad_model
`default_nettype wire

// *** egcp_pkg.sv ***
// Shared constants and types for the expansion GPIO command port
package egcp_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int SAMPLE_PERIOD_US = 31_250;
  localparam int PWM_PERIOD_US = 10_000;
  localparam int SEARCH_TIME_MS = 400;
  localparam int SAMPLE_CYCLES = CLK_PER_US * SAMPLE_PERIOD_US;
  localparam int PWM_STEP_CYCLES = (CLK_PER_US * PWM_PERIOD_US) / 100;
  localparam int SEARCH_CYCLES = CLK_PER_US * 1000 * SEARCH_TIME_MS;

  localparam int NUM_PINS = 5;
  localparam int NUM_MODULES = 1;

  localparam logic [7:0] CMD_TYPE = 8'h25;
  localparam logic [7:0] RSP_TYPE = 8'h65;
  localparam logic [7:0] ERR_TYPE = 8'he5;
  localparam logic [7:0] SUB_GPIO = 8'h05;
  localparam logic [7:0] SUB_SEARCH = 8'h06;
  localparam logic [7:0] LEN_SET = 8'h04;
  localparam logic [7:0] LEN_SET_CFG = 8'h05;
  localparam logic [7:0] LEN_READ = 8'h03;
  localparam logic [7:0] LEN_SEARCH = 8'h01;
  localparam logic [7:0] LEN_READ_RSP = 8'h06;
  localparam logic [7:0] DUTY_HIGH = 8'h64;

  localparam logic [2:0] MODE_UP_RDN = 3'h0;
  localparam logic [2:0] MODE_STRONG = 3'h1;
  localparam logic [2:0] MODE_HIZ = 3'h2;
  localparam logic [2:0] MODE_RUP_DN = 3'h3;
  localparam logic [2:0] MODE_UP_HIZ = 3'h4;
  localparam logic [2:0] MODE_STRONG2 = 3'h5;
  localparam logic [2:0] MODE_RESERVED = 3'h6;
  localparam logic [2:0] MODE_HIZ_DN = 3'h7;

  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_FSEL_BIT = 3;
  localparam int CFG_RSVD_LSB = 4;
  localparam int ST_LEVEL_BIT = 0;
  localparam int ST_FALL_BIT = 1;
  localparam int ST_RISE_BIT = 2;

  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [2:0] RST_MODE = 3'h2;
  localparam logic RST_FSEL = 1'b0;

  localparam logic [7:0] ADDR_CMD_HDR = 8'h00;
  localparam logic [7:0] ADDR_CMD_DATA0 = 8'h04;
  localparam logic [7:0] ADDR_CMD_DATA1 = 8'h08;
  localparam logic [7:0] ADDR_RSP_HDR = 8'h0c;
  localparam logic [7:0] ADDR_RSP_DATA0 = 8'h10;
  localparam logic [7:0] ADDR_RSP_DATA1 = 8'h14;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h18;
  localparam int RSP_BUSY_BIT = 16;
  localparam int RSP_DONE_BIT = 17;
  localparam int RSP_ERR_BIT = 18;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic fsel;
    logic [2:0] mode;
  } egcp_pin_cfg_t;

  typedef struct packed {
    logic oe;
    logic o;
    logic pu;
    logic pd;
  } egcp_pad_drv_t;

  typedef enum logic [2:0] {
    EGCP_IDLE = 3'b001,
    EGCP_EXEC = 3'b010,
    EGCP_SEARCH = 3'b100
  } egcp_state_t;

endpackage : egcp_pkg

// *** egcp_port.sv ***
// Expansion GPIO command port with AXI4-Lite command and response registers
`timescale 1ns/100ps
`default_nettype none
module egcp_port #(
  parameter int SAMPLE_CYCLES = egcp_pkg::SAMPLE_CYCLES,
  parameter int SEARCH_CYCLES = egcp_pkg::SEARCH_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [egcp_pkg::NUM_PINS-1:0] pad_i,
  output logic [egcp_pkg::NUM_PINS-1:0] pad_o,
  output logic [egcp_pkg::NUM_PINS-1:0] pad_oe,
  output logic [egcp_pkg::NUM_PINS-1:0] pull_up,
  output logic [egcp_pkg::NUM_PINS-1:0] pull_down,
  input wire logic [egcp_pkg::NUM_PINS-1:0] default_func_o,
  output logic board_reset
);
  localparam int NP = egcp_pkg::NUM_PINS;
  localparam int SW = $clog2(SEARCH_CYCLES + 1);
  localparam logic [SW-1:0] SEARCH_LAST = SW'(SEARCH_CYCLES - 1);
  localparam int PSW = $clog2(egcp_pkg::PWM_STEP_CYCLES + 1);
  localparam logic [PSW-1:0] PS_LAST = PSW'(egcp_pkg::PWM_STEP_CYCLES - 1);

  if (SEARCH_CYCLES < 2) begin : g_bad
    $error("SEARCH_CYCLES too small");
  end

  function automatic egcp_pkg::egcp_pad_drv_t drive(input logic [2:0] mode, input logic lvl);
    egcp_pkg::egcp_pad_drv_t d;
    d = '0;
    case (mode)
      egcp_pkg::MODE_UP_RDN: begin
        d.oe = lvl;
        d.o = lvl;
        d.pd = !lvl;
      end
      egcp_pkg::MODE_STRONG, egcp_pkg::MODE_STRONG2: begin
        d.oe = 1'b1;
        d.o = lvl;
      end
      egcp_pkg::MODE_RUP_DN: begin
        d.oe = !lvl;
        d.pu = lvl;
      end
      egcp_pkg::MODE_UP_HIZ: begin
        d.oe = lvl;
        d.o = lvl;
      end
      egcp_pkg::MODE_HIZ_DN: begin
        d.oe = !lvl;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction : drive

  egcp_pkg::egcp_state_t state_q;
  logic [31:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic [7:0] cmd_type_q;
  logic [7:0] cmd_len_q;
  logic [7:0] cmd_d_q [5];
  logic [7:0] rsp_type_q;
  logic [7:0] rsp_len_q;
  logic [7:0] rsp_d_q [6];
  logic rsp_done_q;
  logic rsp_err_q;
  logic [7:0] duty_q [NP];
  egcp_pkg::egcp_pin_cfg_t cfg_q [NP];
  logic [SW-1:0] search_cnt_q;
  logic [PSW-1:0] ps_cnt_q;
  logic [6:0] pct_q;
  logic [NP-1:0] clr_q;
  logic [NP-1:0] clr;
  logic [NP-1:0] lvl;
  logic [NP-1:0] rise;
  logic [NP-1:0] fall;
  logic do_write;
  logic start;
  logic [2:0] pin;
  logic ok_mod;
  logic ok_pin;
  logic ok_duty;
  logic ok_cfg;

  egcp_sampler #(
    .N(NP),
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
  ) u_sampler (
    .core_clk(core_clk),
    .nrst(nrst),
    .pad_i(pad_i),
    .clr(clr),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // AXI4-Lite write path: address and data taken in either order
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign start = do_write && wr_addr_q[7:0] == egcp_pkg::ADDR_CMD_HDR && wr_strb_q[0]
                 && state_q == egcp_pkg::EGCP_IDLE;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= egcp_pkg::RESP_OKAY;
      wr_addr_q <= 32'h0000_0000;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr_q[7:0] == egcp_pkg::ADDR_CMD_DATA0
                        || wr_addr_q[7:0] == egcp_pkg::ADDR_CMD_DATA1 || start)
                       ? egcp_pkg::RESP_OKAY : egcp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Command bytes, byte lanes honoured
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmd_type_q <= 8'h00;
      cmd_len_q <= 8'h00;
      for (int i = 0; i < 5; i++) begin
        cmd_d_q[i] <= 8'h00;
      end
    end else if (do_write && state_q == egcp_pkg::EGCP_IDLE) begin
      if (wr_addr_q[7:0] == egcp_pkg::ADDR_CMD_HDR) begin
        if (wr_strb_q[0]) begin
          cmd_type_q <= wr_data_q[7:0];
        end
        if (wr_strb_q[1]) begin
          cmd_len_q <= wr_data_q[15:8];
        end
      end
      if (wr_addr_q[7:0] == egcp_pkg::ADDR_CMD_DATA0) begin
        for (int b = 0; b < 4; b++) begin
          if (wr_strb_q[b]) begin
            cmd_d_q[b] <= wr_data_q[8*b +: 8];
          end
        end
      end
      if (wr_addr_q[7:0] == egcp_pkg::ADDR_CMD_DATA1 && wr_strb_q[0]) begin
        cmd_d_q[4] <= wr_data_q[7:0];
      end
    end
  end

  // Command checks
  assign pin = cmd_d_q[2][2:0];
  assign ok_mod = cmd_d_q[1] < 8'(egcp_pkg::NUM_MODULES);
  assign ok_pin = cmd_d_q[2] < 8'(NP);
  assign ok_duty = cmd_d_q[3] <= egcp_pkg::DUTY_HIGH;
  assign ok_cfg = cmd_d_q[4][7:egcp_pkg::CFG_RSVD_LSB] == 4'h0
                  && cmd_d_q[4][2:0] != egcp_pkg::MODE_RESERVED;

  // Read clears flags in the cycle that captures them, so a new edge survives
  assign clr = clr_q | ((state_q == egcp_pkg::EGCP_EXEC && cmd_type_q == egcp_pkg::CMD_TYPE
                        && cmd_d_q[0] == egcp_pkg::SUB_GPIO && cmd_len_q == egcp_pkg::LEN_READ
                        && ok_mod && ok_pin) ? NP'(1) << pin : '0);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= egcp_pkg::EGCP_IDLE;
      search_cnt_q <= '0;
      board_reset <= 1'b0;
    end else begin
      board_reset <= 1'b0;
      case (state_q)
        egcp_pkg::EGCP_IDLE: begin
          if (start) begin
            state_q <= egcp_pkg::EGCP_EXEC;
          end
        end
        egcp_pkg::EGCP_EXEC: begin
          if (cmd_type_q == egcp_pkg::CMD_TYPE && cmd_d_q[0] == egcp_pkg::SUB_SEARCH
              && cmd_len_q == egcp_pkg::LEN_SEARCH) begin
            state_q <= egcp_pkg::EGCP_SEARCH;
            search_cnt_q <= '0;
            board_reset <= 1'b1;
          end else begin
            state_q <= egcp_pkg::EGCP_IDLE;
          end
        end
        egcp_pkg::EGCP_SEARCH: begin
          if (search_cnt_q == SEARCH_LAST) begin
            state_q <= egcp_pkg::EGCP_IDLE;
          end else begin
            search_cnt_q <= search_cnt_q + SW'(1);
          end
        end
        default: begin
          state_q <= egcp_pkg::EGCP_IDLE;
        end
      endcase
    end
  end

  // Pin settings; search returns them to power-on values
  always_ff @(posedge core_clk) begin
    if (!nrst || board_reset) begin
      for (int i = 0; i < NP; i++) begin
        duty_q[i] <= egcp_pkg::RST_DUTY;
        cfg_q[i] <= '{fsel: egcp_pkg::RST_FSEL, mode: egcp_pkg::RST_MODE};
      end
    end else if (state_q == egcp_pkg::EGCP_EXEC && cmd_type_q == egcp_pkg::CMD_TYPE
                 && cmd_d_q[0] == egcp_pkg::SUB_GPIO && ok_mod && ok_pin && ok_duty) begin
      if (cmd_len_q == egcp_pkg::LEN_SET) begin
        duty_q[pin] <= cmd_d_q[3];
      end else if (cmd_len_q == egcp_pkg::LEN_SET_CFG && ok_cfg) begin
        duty_q[pin] <= cmd_d_q[3];
        cfg_q[pin] <= '{fsel: cmd_d_q[4][egcp_pkg::CFG_FSEL_BIT],
                        mode: cmd_d_q[4][egcp_pkg::CFG_MODE_LSB +: 3]};
      end
    end
  end

  // Response builder
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rsp_type_q <= 8'h00;
      rsp_len_q <= 8'h00;
      rsp_done_q <= 1'b0;
      rsp_err_q <= 1'b0;
      clr_q <= '0;
      for (int i = 0; i < 6; i++) begin
        rsp_d_q[i] <= 8'h00;
      end
    end else begin
      clr_q <= '0;
      if (start) begin
        rsp_done_q <= 1'b0;
        rsp_err_q <= 1'b0;
      end
      if (state_q == egcp_pkg::EGCP_SEARCH && search_cnt_q == SEARCH_LAST) begin
        rsp_type_q <= egcp_pkg::RSP_TYPE;
        rsp_len_q <= egcp_pkg::LEN_SEARCH;
        rsp_d_q[0] <= egcp_pkg::SUB_SEARCH;
        rsp_done_q <= 1'b1;
        clr_q <= '1;
      end
      if (state_q == egcp_pkg::EGCP_EXEC) begin
        rsp_done_q <= 1'b1;
        rsp_type_q <= egcp_pkg::ERR_TYPE;
        rsp_len_q <= 8'h00;
        rsp_err_q <= 1'b1;
        if (cmd_type_q == egcp_pkg::CMD_TYPE && cmd_d_q[0] == egcp_pkg::SUB_SEARCH
            && cmd_len_q == egcp_pkg::LEN_SEARCH) begin
          rsp_done_q <= 1'b0;
          rsp_err_q <= 1'b0;
        end else if (cmd_type_q == egcp_pkg::CMD_TYPE && cmd_d_q[0] == egcp_pkg::SUB_GPIO
                     && ok_mod && ok_pin) begin
          if ((cmd_len_q == egcp_pkg::LEN_SET && ok_duty)
              || (cmd_len_q == egcp_pkg::LEN_SET_CFG && ok_duty && ok_cfg)) begin
            rsp_type_q <= egcp_pkg::RSP_TYPE;
            rsp_err_q <= 1'b0;
          end else if (cmd_len_q == egcp_pkg::LEN_READ) begin
            rsp_type_q <= egcp_pkg::RSP_TYPE;
            rsp_err_q <= 1'b0;
            rsp_len_q <= egcp_pkg::LEN_READ_RSP;
            rsp_d_q[0] <= egcp_pkg::SUB_GPIO;
            rsp_d_q[1] <= cmd_d_q[1];
            rsp_d_q[2] <= cmd_d_q[2];
            rsp_d_q[3] <= 8'h00;
            rsp_d_q[3][egcp_pkg::ST_LEVEL_BIT] <= lvl[pin];
            rsp_d_q[3][egcp_pkg::ST_FALL_BIT] <= fall[pin];
            rsp_d_q[3][egcp_pkg::ST_RISE_BIT] <= rise[pin];
            rsp_d_q[4] <= duty_q[pin];
            rsp_d_q[5] <= {4'h0, cfg_q[pin].fsel, cfg_q[pin].mode};
          end
        end
      end
    end
  end

  // PWM near 100 Hz in percent steps
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ps_cnt_q <= '0;
      pct_q <= 7'h00;
    end else if (ps_cnt_q == PS_LAST) begin
      ps_cnt_q <= '0;
      pct_q <= (pct_q == 7'h63) ? 7'h00 : pct_q + 7'h01;
    end else begin
      ps_cnt_q <= ps_cnt_q + PSW'(1);
    end
  end

  // Pad drive: function picks level source, mode picks drive
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pad_o <= '0;
      pad_oe <= '0;
      pull_up <= '0;
      pull_down <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        logic l;
        egcp_pkg::egcp_pad_drv_t d;
        l = cfg_q[i].fsel ? ({1'b0, pct_q} < duty_q[i]) : default_func_o[i];
        d = drive(cfg_q[i].mode, l);
        pad_o[i] <= d.o;
        pad_oe[i] <= d.oe;
        pull_up[i] <= d.pu;
        pull_down[i] <= d.pd;
      end
    end
  end

  // AXI4-Lite read path, answer one cycle after the address
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= egcp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= egcp_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      case (s_axi_araddr[7:0])
        egcp_pkg::ADDR_CMD_HDR: s_axi_rdata <= {16'h0000, cmd_len_q, cmd_type_q};
        egcp_pkg::ADDR_CMD_DATA0:
          s_axi_rdata <= {cmd_d_q[3], cmd_d_q[2], cmd_d_q[1], cmd_d_q[0]};
        egcp_pkg::ADDR_CMD_DATA1: s_axi_rdata <= {24'h00_0000, cmd_d_q[4]};
        egcp_pkg::ADDR_RSP_HDR: begin
          s_axi_rdata <= {16'h0000, rsp_len_q, rsp_type_q};
          s_axi_rdata[egcp_pkg::RSP_BUSY_BIT] <= state_q != egcp_pkg::EGCP_IDLE;
          s_axi_rdata[egcp_pkg::RSP_DONE_BIT] <= rsp_done_q;
          s_axi_rdata[egcp_pkg::RSP_ERR_BIT] <= rsp_err_q;
        end
        egcp_pkg::ADDR_RSP_DATA0:
          s_axi_rdata <= {rsp_d_q[3], rsp_d_q[2], rsp_d_q[1], rsp_d_q[0]};
        egcp_pkg::ADDR_RSP_DATA1: s_axi_rdata <= {16'h0000, rsp_d_q[5], rsp_d_q[4]};
        egcp_pkg::ADDR_PIN_LEVEL: s_axi_rdata <= {27'h000_0000, lvl};
        default: s_axi_rresp <= egcp_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : egcp_port
`default_nettype wire

// *** egcp_port_checker.sv ***
// Assertion checker for the expansion GPIO command port
`timescale 1ns/100ps
`default_nettype none
module egcp_port_checker #(
  parameter int SAMPLE_CYCLES = 8,
  parameter int SEARCH_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] pad_oe,
  input wire logic [4:0] pull_up,
  input wire logic [4:0] pull_down,
  input wire logic board_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write got no response");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ready_low: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during response");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read got no data");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] > 8'h18
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  a_reset_idle: assert property (
    $rose(nrst) |-> pad_oe == 5'h0 && pull_up == 5'h0 && !board_reset)
    else $error("pins not idle after reset");
  a_board_pulse: assert property (
    board_reset |=> !board_reset [*8]) else $error("board reset pulse too long");
  a_drive_excl: assert property (
    (pad_oe & (pull_up | pull_down)) == 5'h0 && (pull_up & pull_down) == 5'h0)
    else $error("drive and pull overlap");
endmodule : egcp_port_checker
bind egcp_port egcp_port_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .SEARCH_CYCLES(SEARCH_CYCLES))
  u_chk (.core_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_oe, .pull_up, .pull_down,
  .board_reset);
`default_nettype wire

// *** egcp_port_test.sv ***
// Self-checking bench for the expansion GPIO command port
`timescale 1ns/100ps
`default_nettype none
module egcp_port_test;
  localparam logic [47:0] BAD [7] = '{48'h05_0e_6401_0005, 48'h04_00_6501_0005,
    48'h05_1b_6401_0005, 48'h03_00_0005_0005, 48'h03_00_0000_0105, 48'h02_00_0000_0005,
    48'h01_00_0000_0007};
  localparam logic [3:0] HI [8] = '{4'hc, 4'hc, 4'h0, 4'h2, 4'hc, 4'hc, 4'h0, 4'h0};
  localparam logic [3:0] LO [8] = '{4'h1, 4'h8, 4'h0, 4'h8, 4'h0, 4'h8, 4'h0, 4'h8};
  localparam logic [31:0] MSK = 32'h0007_ffff;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, board_reset;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [31:0] s_axi_rdata, rh, r0, r1;
  logic [4:0] pad_i, pad_o, pad_oe, pull_up, pull_down, default_func_o = '0, sw_closed = '0;
  int err_count = 0, checked = 0, cyc = 0, resets = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (board_reset === 1'b1) resets++;
  end
  egcp_port #(.SAMPLE_CYCLES(8), .SEARCH_CYCLES(20)) DUT (.core_clk, .nrst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_i, .pad_o, .pad_oe,
    .pull_up, .pull_down, .default_func_o, .board_reset);
  egcp_pad_model u_pads (.core_clk, .pad_o, .pad_oe, .pull_up, .pull_down, .sw_closed, .pad_i);
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge core_clk);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge core_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task cmd(input logic [7:0] len, input logic [39:0] d);
    int n;
    wr(8'h04, d[31:0]);
    wr(8'h08, {24'h0, d[39:32]});
    wr(8'h00, {16'h0, len, 8'h25});
    n = 0;
    do begin
      rd(8'h0c, rh, rr);
      n++;
    end while (rh[17] !== 1'b1 && n < 100);
    rd(8'h10, r0, rr);
    rd(8'h14, r1, rr);
  endtask : cmd
  task st1(input logic [2:0] e);
    cmd(8'h03, 40'h00_0001_0005);
    chk(32'(r0[26:24]), 32'(e));
  endtask : st1
  task s_read_reset;
    cmd(8'h03, 40'h00_0000_0005);
    chk(rh & MSK, 32'h0002_0665);
    chk(r0 & 32'h00ff_ffff, 32'h0000_0005);
    chk(r1 & 32'h0000_ffff, 32'h0000_0200);
  endtask : s_read_reset
  task s_pullup_edges;
    cmd(8'h05, 40'h0b_6401_0005);
    chk(rh & MSK, 32'h0002_0065);
    chk(32'({pad_oe[1], pull_up[1]}), 32'h1);
    tick(40);
    cmd(8'h03, 40'h00_0001_0005);
    chk(32'(r0[24]), 32'h1);
    rd(8'h18, r1, rr);
    chk(32'(r1[1]), 32'h1);
    sw_closed[1] <= 1'b1;
    tick(40);
    st1(3'h2);
    st1(3'h0);
    sw_closed[1] <= 1'b0;
    tick(40);
    st1(3'h5);
    sw_closed[1] <= 1'b1;
    tick(3);
    sw_closed[1] <= 1'b0;
    tick(40);
    st1(3'h1);
  endtask : s_pullup_edges
  task s_errors;
    for (int i = 0; i < 7; i++) begin
      cmd(BAD[i][47:40], BAD[i][39:0]);
      chk(rh & MSK, 32'h0006_00e5);
    end
    chk(32'({pad_oe[1], pull_up[1]}), 32'h1);
  endtask : s_errors
  task s_default_func;
    default_func_o <= 5'h04;
    cmd(8'h05, 40'h01_0002_0005);
    chk(32'({pad_oe[2], pad_o[2]}), 32'h3);
    default_func_o <= 5'h00;
    tick(3);
    chk(32'({pad_oe[2], pad_o[2]}), 32'h2);
    default_func_o <= 5'h04;
    cmd(8'h05, 40'h09_0002_0005);
    chk(32'({pad_oe[2], pad_o[2]}), 32'h2);
  endtask : s_default_func
  task s_modes;
    for (int m = 0; m < 8; m++) begin
      if (m != 6) begin
        cmd(8'h05, {5'h01, m[2:0], 32'h6403_0005});
        chk(32'({pad_oe[3], pad_oe[3] & pad_o[3], pull_up[3], pull_down[3]}), 32'(HI[m]));
        cmd(8'h05, {5'h01, m[2:0], 32'h0003_0005});
        chk(32'({pad_oe[3], pad_oe[3] & pad_o[3], pull_up[3], pull_down[3]}), 32'(LO[m]));
      end
    end
    cmd(8'h05, 40'h09_3203_0005);
    cmd(8'h03, 40'h00_0003_0005);
    chk(r1 & 32'h0000_ffff, 32'h0000_0932);
  endtask : s_modes
  task s_search;
    int t0, n0;
    t0 = cyc;
    n0 = resets;
    cmd(8'h01, 40'h06);
    chk(rh & MSK, 32'h0002_0165);
    chk(r0 & 32'h0000_00ff, 32'h6);
    chk(32'(resets - n0), 32'h1);
    chk(32'(cyc - t0 >= 20), 32'h1);
    chk(32'({pull_up[1], pad_oe[3]}), 32'h0);
  endtask : s_search
  task s_unmapped;
    rd(8'h1c, r0, rr);
    chk({30'h0, rr}, 32'h2);
    wr(8'h0c, 32'h0);
    chk({30'h0, br}, 32'h2);
  endtask : s_unmapped
  task close_out;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  initial begin
    tick(10);
    nrst <= 1'b1;
    tick(1);
    s_read_reset();
    s_pullup_edges();
    s_errors();
    s_default_func();
    s_modes();
    s_search();
    s_unmapped();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    close_out();
  end
endmodule : egcp_port_test
`default_nettype wire

// *** egcp_sampler.sv ***
// Periodic pin sampler with debounce and latched edge flags
`timescale 1ns/100ps
`default_nettype none
module egcp_sampler #(
  parameter int N = 5,
  parameter int SAMPLE_CYCLES = 1_250_000
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [N-1:0] pad_i,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] level,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  localparam int CW = $clog2(SAMPLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SAMPLE_CYCLES - 1);

  if (SAMPLE_CYCLES < 2) begin : g_bad
    $error("SAMPLE_CYCLES too small");
  end

  logic [CW-1:0] cnt_q;
  logic [N-1:0] prev_q;
  logic tick;
  logic [1:0] warm_q;

  assign tick = (cnt_q == LAST);

  // Sample tick, free running and unrelated to commands
  always_ff @(posedge core_clk) begin
    if (!nrst || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prev_q <= '0;
    end else if (tick) begin
      prev_q <= pad_i;
    end
  end

  // Edges count only once two real samples exist, so reset gives no false edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      warm_q <= 2'b00;
    end else if (tick) begin
      warm_q <= {warm_q[0], 1'b1};
    end
  end

  // Level follows only two agreeing samples
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      level <= '0;
    end else if (tick) begin
      for (int i = 0; i < N; i++) begin
        if (pad_i[i] == prev_q[i]) begin
          level[i] <= pad_i[i];
        end
      end
    end
  end

  // Edge flags stay set until cleared, set wins over clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rise <= '0;
      fall <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (tick && warm_q[1] && pad_i[i] == prev_q[i] && pad_i[i] && !level[i]) begin
          rise[i] <= 1'b1;
        end else if (clr[i]) begin
          rise[i] <= 1'b0;
        end
        if (tick && warm_q[1] && pad_i[i] == prev_q[i] && !pad_i[i] && level[i]) begin
          fall[i] <= 1'b1;
        end else if (clr[i]) begin
          fall[i] <= 1'b0;
        end
      end
    end
  end

endmodule : egcp_sampler
`default_nettype wire
